// ### rtl/sbp_pkg.sv
// constants for the per-port status and control page
// assumes one clock domain, synchronous reset, three ports
package sbp_pkg;
	localparam int NUM_PORTS = 3;
	localparam int SPEED_W = 3;
	// speed codes shared by max, negotiated and cable speed fields
	localparam logic [2:0] SPD_S100 = 3'h0;
	localparam logic [2:0] SPD_S200 = 3'h1;
	localparam logic [2:0] SPD_S400 = 3'h2;
	localparam logic [2:0] SPD_S800 = 3'h3;
	localparam logic [2:0] SPD_S1600 = 3'h4;
	localparam logic [2:0] SPD_S3200 = 3'h5;
	// hardware capability of every port
	localparam logic [2:0] PORT_CAP_SPEED = SPD_S800;
	localparam logic [2:0] MIN_SPEED = SPD_S100;
	localparam logic [2:0] BILINGUAL_BETA_SPEED = SPD_S400;
	// reset values
	localparam logic DIS_RST = 1'b0;
	localparam logic IRQ_EN_RST = 1'b0;
	localparam logic [2:0] MAX_SPEED_RST = PORT_CAP_SPEED;
	localparam logic B_ONLY_VALUE = 1'b0;
	localparam logic LOCAL_PLUG_VALUE = 1'b1;
	// field positions in the per-port status word
	localparam int ST_DIS = 0;
	localparam int ST_IRQ_EN = 1;
	localparam int ST_IRQ_FLAG = 2;
	localparam int ST_FAULT = 3;
	localparam int ST_SB_FAULT = 4;
	localparam int ST_NOSCRM = 5;
	localparam int ST_B_ONLY = 6;
	localparam int ST_DC = 7;
	localparam int ST_PLUG = 8;
	localparam int ST_UNREL = 9;
	localparam int ST_NEG_LO = 10;
	localparam int ST_MAX_LO = 13;
	localparam int ST_CAB_LO = 16;
	localparam int ST_W = 19;
endpackage : sbp_pkg

// ### rtl/sbp_port_regs.sv
// one port's copy of the status and control fields
// assumes all event inputs are already synchronous to mclk
`timescale 1ns/10ps
module sbp_port_regs import sbp_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic bus_reset,
	// register writes aimed at this port
	input wire logic wr_en,
	input wire logic wr_dis,
	input wire logic wr_irq_en,
	input wire logic wr_nosc,
	input wire logic wr_max_en,
	input wire logic [2:0] wr_max,
	input wire logic clr_fault,
	input wire logic clr_sb_fault,
	input wire logic clr_unrel,
	input wire logic clr_irq_flag,
	input wire logic remote_sb_clr,
	// port events and conditions
	input wire logic bilingual,
	input wire logic new_beta_conn,
	input wire logic beta_neg_done,
	input wire logic [2:0] beta_neg_speed,
	input wire logic selfid_done,
	input wire logic [2:0] selfid_speed,
	input wire logic resuming,
	input wire logic suspending,
	input wire logic bias_in,
	input wire logic standby_err,
	input wire logic in_standby,
	input wire logic neg_fail,
	input wire logic sync_fail,
	input wire logic dc_detect,
	input wire logic port_event,
	// results
	output logic [ST_W-1:0] status,
	output logic port_active_ok,
	output logic scramble_en,
	output logic [2:0] beta_speed_limit,
	output logic irq_pulse
);
	logic dis, irq_en, irq_flag, fault, sb_fault, nosc, unrel, dc;
	logic [2:0] neg_speed, max_speed, op_limit;
	logic in_standby_q;
	logic resume_fault, suspend_fault;

	// fault conditions from the peer bias
	assign resume_fault = resuming && !bias_in;
	assign suspend_fault = suspending && bias_in;

	// control bits survive bus reset, cleared by hardware reset or a write of zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			dis <= DIS_RST;
			irq_en <= IRQ_EN_RST;
			nosc <= 1'b0;
		end else if (wr_en) begin
			if (wr_dis) dis <= 1'b1;
			else dis <= 1'b0;
			irq_en <= wr_irq_en;
			nosc <= wr_nosc;
		end
	end

	// max speed clamps to capability; bilingual ports ignore writes
	always_ff @(posedge mclk) begin
		if (rst) begin
			max_speed <= (MAX_SPEED_RST < MIN_SPEED) ? MIN_SPEED : MAX_SPEED_RST;
		end else if (wr_max_en && !bilingual) begin
			max_speed <= (wr_max > PORT_CAP_SPEED) ? PORT_CAP_SPEED : wr_max;
		end
	end

	// non-bilingual limit latched only when a new beta connection forms; bilingual ports hold S400
	always_ff @(posedge mclk) begin
		if (rst) begin
			op_limit <= BILINGUAL_BETA_SPEED;
		end else if (bilingual) begin
			op_limit <= BILINGUAL_BETA_SPEED;
		end else if (new_beta_conn) begin
			op_limit <= max_speed;
		end
	end

	// negotiated speed from beta negotiation or legacy self-id
	always_ff @(posedge mclk) begin
		if (rst) neg_speed <= SPD_S100;
		else if (beta_neg_done) neg_speed <= beta_neg_speed;
		else if (selfid_done) neg_speed <= selfid_speed;
	end

	// sticky flags: a setting event beats a same-cycle clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			fault <= 1'b0;
			unrel <= 1'b0;
			irq_flag <= 1'b0;
		end else begin
			if (resume_fault || suspend_fault) fault <= 1'b1;
			else if (clr_fault) fault <= 1'b0;
			if (neg_fail || sync_fail) unrel <= 1'b1;
			else if (clr_unrel) unrel <= 1'b0;
			if (irq_en && port_event) irq_flag <= 1'b1;
			else if (clr_irq_flag) irq_flag <= 1'b0;
		end
	end

	// standby fault also clears on leaving standby or remote command
	always_ff @(posedge mclk) begin
		if (rst) begin
			sb_fault <= 1'b0;
			in_standby_q <= 1'b0;
		end else begin
			in_standby_q <= in_standby;
			if (standby_err) sb_fault <= 1'b1;
			else if (clr_sb_fault || remote_sb_clr || (in_standby_q && !in_standby))
				sb_fault <= 1'b0;
		end
	end

	// dc connect detect is registered for a clean read
	always_ff @(posedge mclk) begin
		if (rst) dc <= 1'b0;
		else dc <= dc_detect;
	end

	// outputs
	assign port_active_ok = !dis;
	assign scramble_en = !nosc;
	assign beta_speed_limit = op_limit;
	assign irq_pulse = irq_en && port_event;
	always_comb begin
		status = '0;
		status[ST_DIS] = dis;
		status[ST_IRQ_EN] = irq_en;
		status[ST_IRQ_FLAG] = irq_flag;
		status[ST_FAULT] = fault;
		status[ST_SB_FAULT] = sb_fault;
		status[ST_NOSCRM] = nosc;
		status[ST_B_ONLY] = B_ONLY_VALUE;
		status[ST_DC] = dc;
		status[ST_PLUG] = LOCAL_PLUG_VALUE;
		status[ST_UNREL] = unrel;
		status[ST_NEG_LO +: 3] = neg_speed;
		status[ST_MAX_LO +: 3] = max_speed;
		status[ST_CAB_LO +: 3] = PORT_CAP_SPEED;
	end
endmodule : sbp_port_regs

// ### rtl/sbp_status_page.sv
// three-port status and control page with a selected-port access path
// assumes the link side is synchronous to mclk; pins pass two flops
`timescale 1ns/10ps
// What this block does
// - disable bit, hardware reset clears, bus reset keeps
// - disabled port never goes active
// - negotiated speed from beta or self-id
// - enabled port event sets flag, notifies link
// - fault flag set on faults, write-1 clears
// - resume without bias, suspend with bias fault
// - standby fault cleared by exit, write, remote
// - scrambler disable sends data unscrambled
// - beta-only bit always reads zero
// - dc connection bit reflects connect detect
// - speed codes S100 through S3200, two reserved
// - oversized max speed write stores capability
// - max speed used on new beta connection
// - bilingual ports fixed at S400, writes ignored
// - reset max speed is capability, not below minimum
// - local plug flag constant one
// - cable speed reports port capability
// - unreliable set on failures, write-1 clears
module sbp_status_page import sbp_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic bus_reset,
	// link-side access to the selected port
	input wire logic [1:0] port_sel,
	input wire logic wr_en,
	input wire logic wr_dis,
	input wire logic wr_irq_en,
	input wire logic wr_nosc,
	input wire logic wr_max_en,
	input wire logic [2:0] wr_max,
	input wire logic clr_fault,
	input wire logic clr_sb_fault,
	input wire logic clr_unrel,
	input wire logic clr_irq_flag,
	output logic [ST_W-1:0] rd_status,
	// remote command clearing standby fault, per port
	input wire logic [NUM_PORTS-1:0] remote_sb_clr,
	// port mode and state machine events, per port
	input wire logic [NUM_PORTS-1:0] bilingual,
	input wire logic [NUM_PORTS-1:0] new_beta_conn,
	input wire logic [NUM_PORTS-1:0] beta_neg_done,
	input wire logic [3*NUM_PORTS-1:0] beta_neg_speed,
	input wire logic [NUM_PORTS-1:0] selfid_done,
	input wire logic [3*NUM_PORTS-1:0] selfid_speed,
	input wire logic [NUM_PORTS-1:0] resuming,
	input wire logic [NUM_PORTS-1:0] suspending,
	input wire logic [NUM_PORTS-1:0] standby_err,
	input wire logic [NUM_PORTS-1:0] in_standby,
	input wire logic [NUM_PORTS-1:0] neg_fail,
	input wire logic [NUM_PORTS-1:0] sync_fail,
	input wire logic [NUM_PORTS-1:0] port_event,
	// analog detector pins, asynchronous
	input wire logic [NUM_PORTS-1:0] bias_in_pin,
	input wire logic [NUM_PORTS-1:0] dc_detect_pin,
	// controls to the port logic
	output logic [NUM_PORTS-1:0] port_active_ok,
	output logic [NUM_PORTS-1:0] scramble_en,
	output logic [3*NUM_PORTS-1:0] beta_speed_limit,
	output logic link_notify
);
	logic [NUM_PORTS-1:0] bias_s1, bias_s2, dc_s1, dc_s2;
	logic [NUM_PORTS-1:0] irq_pulse;
	logic [ST_W-1:0] status [NUM_PORTS];

	// two-flop synchronisers for detector pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			bias_s1 <= '0;
			bias_s2 <= '0;
			dc_s1 <= '0;
			dc_s2 <= '0;
		end else begin
			bias_s1 <= bias_in_pin;
			bias_s2 <= bias_s1;
			dc_s1 <= dc_detect_pin;
			dc_s2 <= dc_s1;
		end
	end

	// one register copy per port; writes steered by select
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		logic sel;
		assign sel = (port_sel == 2'(p));
		sbp_port_regs u_regs (
			.mclk(mclk),
			.rst(rst),
			.bus_reset(bus_reset),
			.wr_en(wr_en && sel),
			.wr_dis(wr_dis),
			.wr_irq_en(wr_irq_en),
			.wr_nosc(wr_nosc),
			.wr_max_en(wr_max_en && sel),
			.wr_max(wr_max),
			.clr_fault(clr_fault && sel),
			.clr_sb_fault(clr_sb_fault && sel),
			.clr_unrel(clr_unrel && sel),
			.clr_irq_flag(clr_irq_flag && sel),
			.remote_sb_clr(remote_sb_clr[p]),
			.bilingual(bilingual[p]),
			.new_beta_conn(new_beta_conn[p]),
			.beta_neg_done(beta_neg_done[p]),
			.beta_neg_speed(beta_neg_speed[3*p +: 3]),
			.selfid_done(selfid_done[p]),
			.selfid_speed(selfid_speed[3*p +: 3]),
			.resuming(resuming[p]),
			.suspending(suspending[p]),
			.bias_in(bias_s2[p]),
			.standby_err(standby_err[p]),
			.in_standby(in_standby[p]),
			.neg_fail(neg_fail[p]),
			.sync_fail(sync_fail[p]),
			.dc_detect(dc_s2[p]),
			.port_event(port_event[p]),
			.status(status[p]),
			.port_active_ok(port_active_ok[p]),
			.scramble_en(scramble_en[p]),
			.beta_speed_limit(beta_speed_limit[3*p +: 3]),
			.irq_pulse(irq_pulse[p])
		);
	end

	// read data registered; unused select value reads zero
	always_ff @(posedge mclk) begin
		if (rst) rd_status <= '0;
		else if (port_sel < 2'(NUM_PORTS)) rd_status <= status[port_sel];
		else rd_status <= '0;
	end

	// link notified one cycle after any enabled port event
	always_ff @(posedge mclk) begin
		if (rst) link_notify <= 1'b0;
		else link_notify <= |irq_pulse;
	end
endmodule : sbp_status_page

// ### sim/sbp_link_model.sv
// link-side model counting port-event notifications
// assumes notify is a one-cycle pulse synchronous to mclk
`timescale 1ns/10ps
module sbp_link_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// notification from the page
	input wire logic link_notify,
	output int notes
);
	// one count per pulse, so a stuck level over-counts
	always_ff @(posedge mclk) begin
		if (rst) notes <= 0;
		else if (link_notify) notes <= notes + 1;
	end
endmodule : sbp_link_model

// ### sim/sbp_status_props.sv
// checker for the port status page, bound to its top module
// assumes one clock domain and synchronous reset
`timescale 1ns/10ps
module sbp_status_props import sbp_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// watched ports
	input wire logic [1:0] port_sel,
	input wire logic wr_en,
	input wire logic wr_dis,
	input wire logic wr_nosc,
	input wire logic [NUM_PORTS-1:0] bilingual,
	input wire logic [NUM_PORTS-1:0] port_event,
	input wire logic [ST_W-1:0] rd_status,
	input wire logic [NUM_PORTS-1:0] port_active_ok,
	input wire logic [NUM_PORTS-1:0] scramble_en,
	input wire logic [3*NUM_PORTS-1:0] beta_speed_limit,
	input wire logic link_notify
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	dis_ctl_a: assert property (wr_en && port_sel < 2'h3 |=>
		port_active_ok[$past(port_sel)] == !$past(wr_dis)) else $error("disable write lost");
	scram_ctl_a: assert property (wr_en && port_sel < 2'h3 |=>
		scramble_en[$past(port_sel)] == !$past(wr_nosc)) else $error("scrambler write lost");
	b_only_a: assert property (!rd_status[ST_B_ONLY]) else $error("beta-only bit set");
	plug_flag_a: assert property (port_sel != 2'h3 |=> rd_status[ST_PLUG])
		else $error("plug flag low");
	cable_speed_a: assert property (port_sel != 2'h3 |=>
		rd_status[ST_CAB_LO+:3] == PORT_CAP_SPEED) else $error("cable speed wrong");
	notify_cause_a: assert property (link_notify |-> $past(port_event) != 3'h0)
		else $error("notify without event");
	bili_speed_a: assert property (bilingual[2] && $past(bilingual[2]) |->
		beta_speed_limit[8:6] == BILINGUAL_BETA_SPEED) else $error("bilingual limit wrong");
	max_clamp_a: assert property (rd_status[ST_MAX_LO+:3] <= PORT_CAP_SPEED)
		else $error("max speed above capability");
	cover property (link_notify);
	cover property (rd_status[ST_FAULT]);
	cover property (rd_status[ST_UNREL]);
endmodule : sbp_status_props
bind sbp_status_page sbp_status_props chk (.mclk, .rst, .port_sel, .wr_en, .wr_dis, .wr_nosc,
	.bilingual, .port_event, .rd_status, .port_active_ok, .scramble_en, .beta_speed_limit,
	.link_notify);

// ### sim/test_serial_bus_port_status_page.sv
// self-checking bench for the three-port status page
// assumes link model counts notify pulses; pulses packed in pl and ev
`timescale 1ns/10ps
module test_serial_bus_port_status_page import sbp_pkg::*;;
	logic mclk = 0, rst = 1, bus_reset = 0;
	logic [1:0] port_sel = 0, p;
	logic [11:0] pl = 0;
	logic [29:0] ev = 0;
	logic [2:0] bilingual = 3'h4, in_standby = 0, bias_in_pin = 0, dc_detect_pin = 0, d;
	logic [8:0] beta_neg_speed = 0, selfid_speed = 0, beta_speed_limit;
	logic [ST_W-1:0] rd_status, s;
	logic [2:0] port_active_ok, scramble_en, wr_max, ctl [3];
	logic link_notify, wr_en, wr_max_en, clr_fault, clr_sb_fault, clr_unrel, clr_irq_flag;
	logic wr_dis, wr_irq_en, wr_nosc;
	logic [2:0] port_event, sync_fail, neg_fail, standby_err, suspending, resuming;
	logic [2:0] selfid_done, beta_neg_done, new_beta_conn, remote_sb_clr;
	int err_count = 0, check_count = 0, notes, r;
	assign {wr_max, wr_nosc, wr_irq_en, wr_dis, clr_irq_flag, clr_unrel, clr_sb_fault, clr_fault,
		wr_max_en, wr_en} = pl;
	assign {port_event, sync_fail, neg_fail, standby_err, suspending, resuming, selfid_done,
		beta_neg_done, new_beta_conn, remote_sb_clr} = ev;
	always #4 mclk = ~mclk;
	sbp_status_page uut (.*);
	sbp_link_model link (.mclk, .rst, .link_notify, .notes);
	function automatic logic [29:0] e(input int g, input int q);
		return 30'h1 << (3 * g + q);
	endfunction : e
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// pulses last one cycle, then drop
	task op(input logic [1:0] q, input logic [11:0] c, input logic [29:0] v);
		@(posedge mclk);
		port_sel <= q;
		pl <= c;
		ev <= v;
		@(posedge mclk);
		pl <= 0;
		ev <= 0;
	endtask : op
	// status is registered, so wait two edges
	task rd(input logic [1:0] q);
		@(posedge mclk);
		port_sel <= q;
		repeat (2) @(posedge mclk);
		#1 s = rd_status;
	endtask : rd
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test
	// watchdog well beyond the expected few hundred cycles
	initial begin
		repeat (3000) @(posedge mclk);
		err_count++;
		finish_test;
	end
	initial begin
		r = $urandom(98);
		repeat (12) @(posedge mclk);
		rst <= 0;
		for (int q = 0; q < 3; q++) begin
			ctl[q] = 0;
			rd(q[1:0]);
			chk(s, 32'h0003_6100);
		end
		$display("reset values done");
		for (int k = 0; k < 6; k++) begin
			p = 2'($urandom % 3);
			d = 3'($urandom);
			ctl[p] = d;
			op(p, {3'h0, d, 6'h01}, 0);
			for (int q = 0; q < 3; q++) begin
				rd(q[1:0]);
				chk(s & 19'h0_0023, {ctl[q][2], 3'h0, ctl[q][1:0]});
				chk({port_active_ok[q], scramble_en[q]}, {~ctl[q][0], ~ctl[q][2]});
			end
		end
		$display("controls done");
		op(0, 12'h081, 0);
		op(1, 12'h041, 0);
		op(0, 0, e(9, 0) | e(9, 1));
		rd(0);
		chk(s[ST_IRQ_FLAG], 1);
		rd(1);
		chk(s[ST_IRQ_FLAG], 0);
		chk(notes, 1);
		@(posedge mclk) bus_reset <= 1;
		@(posedge mclk) bus_reset <= 0;
		op(0, 12'h020, 0);
		rd(0);
		chk(s[2:0], 3'h2);
		rd(1);
		chk(s[1:0], 2'h1);
		$display("events done");
		for (int v = 7; v >= 0; v--) begin
			op(1, {3'(v), 9'h002}, 0);
			rd(1);
			chk(s[ST_MAX_LO+:3], v > 3 ? 3 : v);
		end
		op(1, 0, e(1, 1));
		rd(1);
		chk(beta_speed_limit[5:3], SPD_S100);
		op(2, 12'h202, 0);
		rd(2);
		chk(s[ST_MAX_LO+:3], 3'h3);
		chk(beta_speed_limit[8:6], SPD_S400);
		op(0, 0, e(4, 0));
		rd(0);
		chk(s[ST_FAULT], 1);
		op(0, 12'h004, 0);
		rd(0);
		chk(s[ST_FAULT], 0);
		@(posedge mclk) bias_in_pin <= 3'h2;
		repeat (3) @(posedge mclk);
		op(1, 0, e(5, 1));
		rd(1);
		chk(s[ST_FAULT], 1);
		// clear by remote command, by write, then by leaving standby
		for (int i = 0; i < 3; i++) begin
			op(2, 0, e(6, 2));
			rd(2);
			chk(s[ST_SB_FAULT], 1);
			if (i == 2) begin
				@(posedge mclk) in_standby <= 3'h4;
				@(posedge mclk) in_standby <= 3'h0;
			end
			op(2, i == 1 ? 12'h008 : 12'h000, i == 0 ? e(0, 2) : 30'h0);
			rd(2);
			chk(s[ST_SB_FAULT], 0);
		end
		for (int g = 7; g < 9; g++) begin
			op(1, 0, e(g, 1));
			rd(1);
			chk(s[ST_UNREL], 1);
			op(1, 12'h010, 0);
			rd(1);
			chk(s[ST_UNREL], 0);
		end
		$display("faults done");
		d = 3'(1 + $urandom % 3);
		@(posedge mclk) selfid_speed <= {3{d}};
		beta_neg_speed <= {3{d}};
		op(0, 0, e(3, 0) | e(2, 1));
		rd(0);
		chk(s[ST_NEG_LO+:3], d);
		rd(1);
		chk(s[ST_NEG_LO+:3], d);
		@(posedge mclk) dc_detect_pin <= 3'h2;
		repeat (3) @(posedge mclk);
		rd(1);
		chk(s[ST_DC], 1);
		rd(0);
		chk(s[ST_DC], 0);
		$display("speeds done");
		finish_test;
	end
endmodule : test_serial_bus_port_status_page
